//--- include/ppl_defines.svh
`ifndef PPL_DEFINES_SVH
`define PPL_DEFINES_SVH

// ----------------------------------------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------------------------------------
`define PPL_IDX_SETUP    16'h60B8
`define PPL_IDX_STATUS   16'h60B9
`define PPL_IDX_POS_BASE 16'h60BA
`define PPL_IDX_INT_STAT 16'h60C0
`define PPL_IDX_INT_MASK 16'h60C1

// ----------------------------------------------------------------------
// Reset values of the setting word and interrupt registers, and writable bits of the setting word
// ----------------------------------------------------------------------
`define PPL_SETUP_RST    16'h0000
`define PPL_SETUP_MASK   16'h3737
`define PPL_INT_RST      4'h0

// ----------------------------------------------------------------------
// Field positions within one probe byte
// ----------------------------------------------------------------------
`define PPL_STRIDE       8
`define PPL_CFG_EN       0
`define PPL_CFG_MODE     1
`define PPL_CFG_SRC      2
`define PPL_CFG_RISE     4
`define PPL_CFG_FALL     5
`define PPL_ST_EN        0
`define PPL_ST_RISE      1
`define PPL_ST_FALL      2
`define PPL_ST_SRC       6
`define PPL_ST_LVL       7

`endif

//--- include/ppl_pkg.sv
package ppl_pkg;

   typedef enum logic [1:0] {PR_IDLE, PR_ARMED, PR_DONE} ppl_state_t;

endpackage

//--- verilog/ppl_probe_latch.sv
`timescale 1ns/1ps
`include "ppl_defines.svh"

module ppl_probe_latch
   import ppl_pkg::*;
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic [17:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Trigger pins and position source
   input  wire logic        probe_one_digital_input,
   input  wire logic        probe_two_digital_input,
   input  wire logic        motor_index_pulse,
   input  wire logic [31:0] encoder_position,
   // Interrupt
   output logic             irq
);

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   logic [15:0]  setup_q;
   logic [1:0]   en_prev_q;
   ppl_state_t   st_q [2];
   logic [1:0]   rise_seen_q;
   logic [1:0]   fall_seen_q;
   logic [31:0]  pos_q [4];
   logic [3:0]   int_stat_q;
   logic [3:0]   int_mask_q;
   logic [2:0]   sync1_q;
   logic [2:0]   sync2_q;
   logic [2:0]   sync3_q;
   logic [31:0]  prdata_q;
   logic         pready_q;
   logic         pslverr_q;
   logic         irq_q;
   logic [1:0]   start;
   logic [1:0]   lvl;
   logic [1:0]   lvl_prev;
   logic [1:0]   rise_ev;
   logic [1:0]   fall_ev;
   logic [3:0]   cap;
   logic [15:0]  status;
   logic [31:0]  rd_data;
   logic         addr_ok;
   logic         wr_en;
   logic [15:0]  reg_idx;

   function automatic logic cfg_bit(input logic [15:0] w, input int p, input int b);
      return w[p * `PPL_STRIDE + b];
   endfunction

   function automatic logic idx_valid(input logic [15:0] idx);
      return (idx >= `PPL_IDX_SETUP && idx <= `PPL_IDX_POS_BASE + 16'h0003) ||
             idx == `PPL_IDX_INT_STAT || idx == `PPL_IDX_INT_MASK;
   endfunction

   // ----------------------------------------------------------------------
   // APB slave: one wait state, write commits at the edge with pready high
   // ----------------------------------------------------------------------
   assign reg_idx = paddr[17:2];
   assign addr_ok = idx_valid(reg_idx);
   assign wr_en   = psel & penable & pready_q & pwrite & ~pslverr_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h00000000;
      end else begin
         pready_q  <= psel & penable & ~pready_q;
         pslverr_q <= psel & penable & ~pready_q & ~addr_ok;
         if (psel & penable & ~pready_q & ~pwrite) begin
            prdata_q <= addr_ok ? rd_data : 32'h00000000;
         end
      end
   end

   always_comb begin
      rd_data = 32'h00000000;
      case (reg_idx)
         `PPL_IDX_SETUP:              rd_data = {16'h0000, setup_q};
         `PPL_IDX_STATUS:             rd_data = {16'h0000, status};
         `PPL_IDX_POS_BASE:           rd_data = pos_q[0];
         `PPL_IDX_POS_BASE + 16'h0001: rd_data = pos_q[1];
         `PPL_IDX_POS_BASE + 16'h0002: rd_data = pos_q[2];
         `PPL_IDX_POS_BASE + 16'h0003: rd_data = pos_q[3];
         `PPL_IDX_INT_STAT:           rd_data = {28'h0000000, int_stat_q};
         `PPL_IDX_INT_MASK:           rd_data = {28'h0000000, int_mask_q};
         default:                     rd_data = 32'h00000000;
      endcase
   end

   // ----------------------------------------------------------------------
   // Setting word
   // ----------------------------------------------------------------------
   // Only the enable bit of a running probe accepts writes, so the trigger
   // path can never see a half-changed configuration. A write that clears
   // enable keeps the old settings, so software must stop a probe first and
   // reconfigure it with a second write.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         setup_q <= `PPL_SETUP_RST;
      end else if (wr_en && reg_idx == `PPL_IDX_SETUP) begin
         for (int p = 0; p < 2; p++) begin
            if (cfg_bit(setup_q, p, `PPL_CFG_EN)) begin
               setup_q[p*`PPL_STRIDE] <= pwdata[p*`PPL_STRIDE];
            end else begin
               setup_q[p*`PPL_STRIDE +: 8] <= pwdata[p*`PPL_STRIDE +: 8] & 8'h37;
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // Trigger synchronisers and edge detection
   // ----------------------------------------------------------------------
   // Two stages guard against metastability and the third holds the previous
   // level for edge detection; the price is three cycles of capture latency.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= 3'h0;
         sync2_q <= 3'h0;
         sync3_q <= 3'h0;
      end else begin
         sync1_q <= {motor_index_pulse, probe_two_digital_input, probe_one_digital_input};
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   always_comb begin
      for (int p = 0; p < 2; p++) begin
         start[p]    = cfg_bit(setup_q, p, `PPL_CFG_EN) & ~en_prev_q[p];
         lvl[p]      = cfg_bit(setup_q, p, `PPL_CFG_SRC) ? sync2_q[2] : sync2_q[p];
         lvl_prev[p] = cfg_bit(setup_q, p, `PPL_CFG_SRC) ? sync3_q[2] : sync3_q[p];
         rise_ev[p]  = lvl[p] & ~lvl_prev[p] & cfg_bit(setup_q, p, `PPL_CFG_RISE);
         fall_ev[p]  = ~lvl[p] & lvl_prev[p] & cfg_bit(setup_q, p, `PPL_CFG_FALL);
         cap[2*p]    = (st_q[p] == PR_ARMED) & rise_ev[p];
         cap[2*p+1]  = (st_q[p] == PR_ARMED) & fall_ev[p];
      end
   end

   // ----------------------------------------------------------------------
   // Probe state machines
   // ----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_prev_q <= 2'h0;
         st_q[0]   <= PR_IDLE;
         st_q[1]   <= PR_IDLE;
      end else begin
         for (int p = 0; p < 2; p++) begin
            en_prev_q[p] <= cfg_bit(setup_q, p, `PPL_CFG_EN);
            case (st_q[p])
               PR_IDLE: begin
                  if (start[p]) begin
                     st_q[p] <= PR_ARMED;
                  end
               end
               PR_ARMED: begin
                  if (!cfg_bit(setup_q, p, `PPL_CFG_EN)) begin
                     st_q[p] <= PR_IDLE;
                  end else if ((cap[2*p] | cap[2*p+1]) && !cfg_bit(setup_q, p, `PPL_CFG_MODE)) begin
                     st_q[p] <= PR_DONE;
                  end
               end
               PR_DONE: begin
                  if (!cfg_bit(setup_q, p, `PPL_CFG_EN)) begin
                     st_q[p] <= PR_IDLE;
                  end
               end
               default: st_q[p] <= PR_IDLE;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // Captured positions and latched flags
   // ----------------------------------------------------------------------
   // Flags are cleared on a fresh start, so they report edges of this run.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rise_seen_q <= 2'h0;
         fall_seen_q <= 2'h0;
         for (int k = 0; k < 4; k++) begin
            pos_q[k] <= 32'h00000000;
         end
      end else begin
         for (int p = 0; p < 2; p++) begin
            if (start[p]) begin
               rise_seen_q[p] <= 1'b0;
               fall_seen_q[p] <= 1'b0;
            end
            if (cap[2*p]) begin
               pos_q[2*p]     <= encoder_position;
               rise_seen_q[p] <= 1'b1;
            end
            if (cap[2*p+1]) begin
               pos_q[2*p+1]   <= encoder_position;
               fall_seen_q[p] <= 1'b1;
            end
         end
      end
   end

   always_comb begin
      status = 16'h0000;
      for (int p = 0; p < 2; p++) begin
         status[p*`PPL_STRIDE + `PPL_ST_EN]   = st_q[p] != PR_IDLE;
         status[p*`PPL_STRIDE + `PPL_ST_RISE] = rise_seen_q[p];
         status[p*`PPL_STRIDE + `PPL_ST_FALL] = fall_seen_q[p];
         status[p*`PPL_STRIDE + `PPL_ST_SRC]  = cfg_bit(setup_q, p, `PPL_CFG_SRC);
         status[p*`PPL_STRIDE + `PPL_ST_LVL]  = lvl[p];
      end
   end

   // ----------------------------------------------------------------------
   // Interrupts: capture events, write one to clear, set wins
   // ----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_stat_q <= `PPL_INT_RST;
         int_mask_q <= `PPL_INT_RST;
         irq_q      <= 1'b0;
      end else begin
         if (wr_en && reg_idx == `PPL_IDX_INT_STAT) begin
            int_stat_q <= (int_stat_q & ~pwdata[3:0]) | cap;
         end else begin
            int_stat_q <= int_stat_q | cap;
         end
         if (wr_en && reg_idx == `PPL_IDX_INT_MASK) begin
            int_mask_q <= pwdata[3:0];
         end
         irq_q <= |(int_stat_q & int_mask_q);
      end
   end

   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;
   assign irq     = irq_q;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_p0_hit;
      st_q[0] == PR_ARMED && (rise_ev[0] || fall_ev[0]) && setup_q[0];
   endsequence

   sequence s_p1_hit;
      st_q[1] == PR_ARMED && (rise_ev[1] || fall_ev[1]) && setup_q[8];
   endsequence

   sequence s_p0_start;
      start[0] && st_q[0] == PR_IDLE;
   endsequence

   sequence s_p1_start;
      start[1] && st_q[1] == PR_IDLE;
   endsequence

   a_start_arms: assert property (start[0] && st_q[0] == PR_IDLE |=> st_q[0] == PR_ARMED)
      else $error("probe one did not arm on enable");
   a_single_done: assert property (s_p0_hit ##0 !setup_q[1] |=> st_q[0] == PR_DONE)
      else $error("probe one single mode did not stop");
   a_cont_armed: assert property (s_p1_hit ##0 setup_q[9] |=> st_q[1] == PR_ARMED)
      else $error("probe two continuous mode stopped");
   a_done_quiet: assert property (st_q[0] == PR_DONE && $past(st_q[0]) == PR_DONE |-> $stable(pos_q[0]))
      else $error("probe one captured after single trigger");
   a_rise_capture: assert property (s_p0_hit ##0 rise_ev[0] |=> pos_q[0] == $past(encoder_position))
      else $error("probe one rising position not captured");
   a_index_src: assert property (st_q[1] == PR_ARMED && setup_q[10] && setup_q[12]
      && sync2_q[2] && !sync3_q[2] |=> rise_seen_q[1])
      else $error("probe two missed index edge");
   a_fall_gate: assert property (!setup_q[5] |=> $stable(pos_q[1]))
      else $error("probe one falling latch while disabled");
   a_freeze_one: assert property (setup_q[0] && $past(setup_q[0]) |-> setup_q[5:1] == $past(setup_q[5:1]))
      else $error("probe one settings changed while enabled");
   a_freeze_two: assert property (setup_q[8] && $past(setup_q[8]) |-> setup_q[13:9] == $past(setup_q[13:9]))
      else $error("probe two settings changed while enabled");
   a_reserved_zero: assert property ((setup_q & ~`PPL_SETUP_MASK) == 16'h0000)
      else $error("reserved setting bits set");
   a_disable_stop: assert property (!setup_q[8] && st_q[1] != PR_IDLE |=> st_q[1] == PR_IDLE)
      else $error("probe two did not stop on disable");
   a_status_en: assert property (s_p0_start |=> status[0] && !status[1] && !status[2])
      else $error("probe one status not fresh after start");

   // ----------------------------------------------------------------------
   // Assertions: mirror checks for the other probe and the edge gates
   // ----------------------------------------------------------------------
   a_start_two: assert property (s_p1_start |=> st_q[1] == PR_ARMED)
      else $error("probe two did not arm on enable");
   a_cont_one: assert property (s_p0_hit ##0 setup_q[1] |=> st_q[0] == PR_ARMED)
      else $error("probe one continuous mode stopped");
   a_single_two: assert property (s_p1_hit ##0 !setup_q[9] |=> st_q[1] == PR_DONE)
      else $error("probe two single mode did not stop");
   a_done_two: assert property (st_q[1] == PR_DONE && $past(st_q[1]) == PR_DONE
      |-> $stable(pos_q[2]) && $stable(pos_q[3]))
      else $error("probe two captured after single trigger");
   a_index_one: assert property (st_q[0] == PR_ARMED && setup_q[2] && setup_q[5]
      && !sync2_q[2] && sync3_q[2] |=> fall_seen_q[0])
      else $error("probe one missed index falling edge");
   a_digital_two: assert property (st_q[1] == PR_ARMED && !setup_q[10] && setup_q[12] && setup_q[13]
      && sync2_q[1] != sync3_q[1] |=> rise_seen_q[1] || fall_seen_q[1])
      else $error("probe two missed a digital input edge");
   a_rise_gate: assert property (!setup_q[4] |=> $stable(pos_q[0]))
      else $error("probe one rising latch while disabled");
   a_rise_gate_two: assert property (!setup_q[12] |=> $stable(pos_q[2]))
      else $error("probe two rising latch while disabled");
   a_fall_capture: assert property (s_p1_hit ##0 fall_ev[1] |=> pos_q[3] == $past(encoder_position))
      else $error("probe two falling position not captured");
   a_disable_one: assert property (!setup_q[0] && st_q[0] != PR_IDLE |=> st_q[0] == PR_IDLE)
      else $error("probe one did not stop on disable");
   a_idle_quiet: assert property (st_q[0] == PR_IDLE |=> $stable(pos_q[0]) && $stable(pos_q[1]))
      else $error("idle probe one captured a position");

endmodule

//--- test/ppl_far_side.sv
`timescale 1ns/1ps

// Drives the trigger pins and a free-running encoder count, as the machine would.
module ppl_far_side (
   // Clock
   input  wire logic        pclk,
   // Trigger pins and position
   output logic             probe_one_digital_input,
   output logic             probe_two_digital_input,
   output logic             motor_index_pulse,
   output logic      [31:0] encoder_position
);
   logic [2:0] pin_q = 3'h0;

   assign probe_one_digital_input = pin_q[0];
   assign probe_two_digital_input = pin_q[1];
   assign motor_index_pulse       = pin_q[2];

   // Starts near the top, so the count wraps 16 cycles in, before the first capture.
   initial encoder_position = 32'hFFFFFFF0;
   always @(posedge pclk) begin
      encoder_position <= encoder_position + 32'h1;
   end

   // One high pulse on pin k; each level lasts long enough for the synchroniser.
   task automatic pulse(input int k, output logic [31:0] er, output logic [31:0] ef);
      @(posedge pclk);
      pin_q[k] <= 1'b1;
      er = encoder_position;
      repeat (8) @(posedge pclk);
      pin_q[k] <= 1'b0;
      ef = encoder_position;
      repeat (8) @(posedge pclk);
   endtask
endmodule

//--- test/testbench.sv
`timescale 1ns/1ps
`include "ppl_defines.svh"

module testbench;
   logic        pclk;
   logic        presetn;
   logic [17:0] paddr;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq;
   logic        probe_one_digital_input;
   logic        probe_two_digital_input;
   logic        motor_index_pulse;
   logic [31:0] encoder_position;
   logic [31:0] rd;
   logic        err;
   int          fail_count = 0;
   int          tests_run = 0;
   int          cycles = 0;
   int          seed = 47360;

   ppl_probe_latch dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
      .pslverr, .probe_one_digital_input, .probe_two_digital_input, .motor_index_pulse, .encoder_position, .irq);

   ppl_far_side far_u (.pclk, .probe_one_digital_input, .probe_two_digital_input, .motor_index_pulse,
      .encoder_position);

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         summarize();
      end
   end

   // ----------------------------------------------------------------------
   // Bus and comparison helpers
   // ----------------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic [15:0] idx, input logic wr, input logic [31:0] wd);
      @(posedge pclk);
      psel    <= 1'b1;
      paddr   <= {idx, 2'b00};
      pwrite  <= wr;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdck(input logic [15:0] idx, input logic [31:0] exp);
      apb(idx, 1'b0, 32'h0);
      check(rd, exp);
   endtask

   // Single mode stops at the first enabled edge, so a falling capture needs
   // continuous mode or a disabled rising edge.
   function automatic logic [1:0] exp_caps(input logic cont, input logic rise, input logic fall);
      return {fall & (cont | ~rise), rise};
   endfunction

   // A capture must land a few cycles after the pin edge, otherwise the old value stays.
   task automatic pos_ck(input logic [31:0] got, old, input logic cap, input logic [31:0] e);
      logic [31:0] d;
      d = got - e;
      check({31'h0, cap ? (d >= 32'h2 && d <= 32'h8) : (got === old)}, 32'h1);
   endtask

   // ----------------------------------------------------------------------
   // One random probe run
   // ----------------------------------------------------------------------
   task automatic run_case(input int p);
      logic [31:0] r, oldr, oldf, pr, ex, er1, ef1, er2, ef2;
      logic [7:0]  cfg;
      logic        rcap, fcap;
      int          sh;
      r = $random(seed);
      sh = p * 8;
      cfg = {2'b00, r[3], r[2], 1'b0, r[1], r[0], 1'b0};
      {fcap, rcap} = exp_caps(r[0], r[2], r[3]);
      ex = {30'h0, fcap, rcap} << (2 * p);
      apb(`PPL_IDX_INT_MASK, 1'b1, {28'h0, r[7:4]});
      apb(`PPL_IDX_SETUP, 1'b1, ({24'h0, cfg} << sh) | {16'h0, r[31:16] & 16'hC8C8});
      rdck(`PPL_IDX_SETUP, {24'h0, cfg} << sh);
      apb(`PPL_IDX_SETUP, 1'b1, {24'h0, cfg | 8'h01} << sh);
      apb(`PPL_IDX_SETUP, 1'b1, {24'h0, (cfg ^ 8'h36) | 8'h01} << sh);
      rdck(`PPL_IDX_SETUP, {24'h0, cfg | 8'h01} << sh);
      apb(`PPL_IDX_POS_BASE + 16'(2 * p), 1'b0, 32'h0);
      oldr = rd;
      apb(`PPL_IDX_POS_BASE + 16'(2 * p + 1), 1'b0, 32'h0);
      oldf = rd;
      // The unselected source is pulsed first and must leave no trace.
      far_u.pulse(r[1] ? p : 2, er1, ef1);
      far_u.pulse(r[1] ? 2 : p, er1, ef1);
      far_u.pulse(r[1] ? 2 : p, er2, ef2);
      apb(`PPL_IDX_POS_BASE + 16'(2 * p), 1'b0, 32'h0);
      pr = rd;
      apb(`PPL_IDX_POS_BASE + 16'(2 * p + 1), 1'b0, 32'h0);
      pos_ck(pr, oldr, rcap, r[0] ? er2 : er1);
      pos_ck(rd, oldf, fcap, r[0] ? ef2 : ef1);
      apb(`PPL_IDX_STATUS, 1'b0, 32'h0);
      check((rd >> sh) & 32'hFF, {24'h0, 1'b0, r[1], 3'b000, fcap, rcap, 1'b1});
      rdck(`PPL_IDX_INT_STAT, ex);
      check({31'h0, irq}, {31'h0, |(ex[3:0] & r[7:4])});
      apb(`PPL_IDX_SETUP, 1'b1, 32'h0);
      rdck(`PPL_IDX_SETUP, {24'h0, cfg} << sh);
      apb(`PPL_IDX_INT_STAT, 1'b1, 32'hF);
      rdck(`PPL_IDX_INT_STAT, 32'h0);
      check({31'h0, irq}, 32'h0);
   endtask

   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      presetn = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 18'h0;
      pwdata  = 32'h0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      // Position registers are read only, so this write must be dropped.
      apb(`PPL_IDX_POS_BASE, 1'b1, 32'h1234);
      for (int k = 0; k < 6; k++) begin
         rdck(`PPL_IDX_SETUP + 16'(k), 32'h0);
      end
      rdck(`PPL_IDX_INT_STAT, 32'h0);
      rdck(`PPL_IDX_INT_MASK, 32'h0);
      apb(16'h60C5, 1'b0, 32'h0);
      check({31'h0, err}, 32'h1);
      check(rd, 32'h0);
      for (int i = 0; i < 24; i++) begin
         run_case(i % 2);
      end
      summarize();
   end
endmodule
